// >>> design/pscr_relay.sv
`timescale 1ns/1ps
module pscr_relay #(
   parameter int unsigned HIGH_TICKS = pscr_pkg::HIGH_TICKS,
   parameter int unsigned TIMEOUT_TICKS = pscr_pkg::TIMEOUT_TICKS,
   parameter int unsigned DATA_W = pscr_pkg::DATA_W,
   parameter int unsigned FIFO_DEPTH = pscr_pkg::FIFO_DEPTH
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic chain_in,
   input wire logic mode_select_pin,
   input wire logic meas_valid,
   input wire logic [DATA_W-1:0] meas_data,
   output logic meas_ready,
   output logic chain_out,
   output logic conv_start,
   output logic powered,
   output logic osc_settled,
   output logic busy
);
   localparam int unsigned CW = pscr_pkg::CNT_W;
   localparam int unsigned DW = pscr_pkg::DLY_TICKS;
   localparam int unsigned DIVW = pscr_pkg::DIV_W;

   // ==================================================
   // measurement buffer
   // ==================================================
   pscr_stream_if #(.W(DATA_W)) fill_if ();
   pscr_stream_if #(.W(DATA_W)) drain_if ();

   assign fill_if.valid = meas_valid;
   assign fill_if.data = meas_data;
   assign meas_ready = fill_if.ready;

   pscr_fifo #(
      .W(DATA_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk(ref_clk),
      .rst(rst),
      .wr(fill_if),
      .rd(drain_if)
   );

   // ==================================================
   // pin synchronisers and strap
   // ==================================================
   logic [1:0] in_sync_q, in_sync_d, mode_sync_q, mode_sync_d;
   logic [1:0] strap_cnt_q, strap_cnt_d;
   logic daisy_q, daisy_d, strap_done_q, strap_done_d;

   always_comb begin
      in_sync_d = {in_sync_q[0], chain_in};
      mode_sync_d = {mode_sync_q[0], mode_select_pin};
      strap_cnt_d = strap_cnt_q;
      strap_done_d = strap_done_q;
      daisy_d = daisy_q;
      if (!strap_done_q) begin
         strap_cnt_d = strap_cnt_q + 2'h1;
         if (strap_cnt_q == 2'(pscr_pkg::STRAP_WAIT)) begin
            daisy_d = mode_sync_q[1];
            strap_done_d = 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         in_sync_q <= 2'h0;
         mode_sync_q <= 2'h0;
         strap_cnt_q <= 2'h0;
         strap_done_q <= 1'b0;
         daisy_q <= 1'b0;
      end else begin
         in_sync_q <= in_sync_d;
         mode_sync_q <= mode_sync_d;
         strap_cnt_q <= strap_cnt_d;
         strap_done_q <= strap_done_d;
         daisy_q <= daisy_d;
      end
   end

   // ==================================================
   // microsecond tick from the oscillator
   // ==================================================
   logic [DIVW-1:0] div_q, div_d;
   logic tick;

   always_comb begin
      tick = (div_q == DIVW'(pscr_pkg::TICK_CYCLES - 1));
      div_d = tick ? '0 : div_q + DIVW'(1);
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         div_q <= '0;
      end else begin
         div_q <= div_d;
      end
   end

   // ==================================================
   // input high-width classifier
   // ==================================================
   logic in_prev_q, in_prev_d;
   logic [CW-1:0] hi_cnt_q, hi_cnt_d;
   logic in_lvl, rise, fall, start_det, warm_det, timed_out;

   always_comb begin
      in_lvl = in_sync_q[1];
      rise = in_lvl & ~in_prev_q;
      fall = ~in_lvl & in_prev_q;
      in_prev_d = in_lvl;
      hi_cnt_d = hi_cnt_q;
      if (rise) begin
         hi_cnt_d = '0;
      end else if (in_lvl & tick & (hi_cnt_q < CW'(TIMEOUT_TICKS))) begin
         hi_cnt_d = hi_cnt_q + CW'(1);
      end
      start_det = fall & (hi_cnt_q <= CW'(pscr_pkg::START_MAX_TICKS));
      warm_det = fall & (hi_cnt_q >= CW'(pscr_pkg::WARM_MIN_TICKS));
      timed_out = in_lvl & (hi_cnt_q >= CW'(TIMEOUT_TICKS));
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         in_prev_q <= 1'b0;
         hi_cnt_q <= '0;
      end else begin
         in_prev_q <= in_prev_d;
         hi_cnt_q <= hi_cnt_d;
      end
   end

   // ==================================================
   // power state
   // ==================================================
   logic pwr_q, pwr_d, settled_q, settled_d;

   always_comb begin
      pwr_d = pwr_q;
      settled_d = settled_q;
      if (timed_out) begin
         pwr_d = 1'b0;
         settled_d = 1'b0;
      end
      if (warm_det) begin
         pwr_d = 1'b1;
         settled_d = 1'b1;
      end else if (start_det) begin
         pwr_d = 1'b1;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         pwr_q <= 1'b1;
         settled_q <= 1'b0;
      end else begin
         pwr_q <= pwr_d;
         settled_q <= settled_d;
      end
   end

   // ==================================================
   // relay and own-measurement sequencer
   // ==================================================
   pscr_pkg::pscr_state_e st_q, st_d;
   logic [CW-1:0] ph_q, ph_d;
   logic [DATA_W-1:0] low_q, low_d;
   logic [DW-1:0] dly_q, dly_d;
   logic out_q, out_d, conv_q, conv_d, busy_q, busy_d;

   // pop only while waiting; the converter stalls on drain_if.valid
   assign drain_if.ready = (st_q == pscr_pkg::ST_CONVERT);

   always_comb begin
      st_d = st_q;
      ph_d = ph_q;
      low_d = low_q;
      dly_d = dly_q;
      out_d = out_q;
      conv_d = 1'b0;
      unique case (st_q)
         pscr_pkg::ST_RELAY: begin
            if (tick) begin
               dly_d = {dly_q[DW-2:0], in_lvl};
            end
            out_d = daisy_q & dly_q[DW-1];
            if (daisy_q & start_det) begin
               st_d = pscr_pkg::ST_CONVERT;
               conv_d = 1'b1;
               dly_d = '0;
               out_d = 1'b0;
            end
         end
         pscr_pkg::ST_CONVERT: begin
            out_d = 1'b0;
            if (drain_if.valid) begin
               low_d = drain_if.data;
               ph_d = '0;
               out_d = 1'b1;
               st_d = pscr_pkg::ST_OWN_HIGH;
            end
         end
         pscr_pkg::ST_OWN_HIGH: begin
            if (tick) begin
               ph_d = ph_q + CW'(1);
               if (ph_q == CW'(HIGH_TICKS - 1)) begin
                  ph_d = '0;
                  out_d = 1'b0;
                  st_d = pscr_pkg::ST_OWN_LOW;
               end
            end
         end
         pscr_pkg::ST_OWN_LOW: begin
            if (tick) begin
               ph_d = ph_q + CW'(1);
               if ((ph_q + CW'(1)) >= CW'(low_q)) begin
                  ph_d = '0;
                  out_d = 1'b1;
                  st_d = pscr_pkg::ST_START_OUT;
               end
            end
         end
         pscr_pkg::ST_START_OUT: begin
            if (tick) begin
               ph_d = ph_q + CW'(1);
               if (ph_q == CW'(pscr_pkg::START_OUT_TICKS - 1)) begin
                  ph_d = '0;
                  out_d = 1'b0;
                  st_d = pscr_pkg::ST_RELAY;
               end
            end
         end
         default: begin
            st_d = pscr_pkg::ST_RELAY;
            out_d = 1'b0;
         end
      endcase
      busy_d = (st_d != pscr_pkg::ST_RELAY);
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         st_q <= pscr_pkg::ST_RELAY;
         ph_q <= '0;
         low_q <= '0;
         dly_q <= '0;
         out_q <= 1'b0;
         conv_q <= 1'b0;
         busy_q <= 1'b0;
      end else begin
         st_q <= st_d;
         ph_q <= ph_d;
         low_q <= low_d;
         dly_q <= dly_d;
         out_q <= out_d;
         conv_q <= conv_d;
         busy_q <= busy_d;
      end
   end

   assign chain_out = out_q;
   assign conv_start = conv_q;
   assign powered = pwr_q;
   assign osc_settled = settled_q;
   assign busy = busy_q;
endmodule : pscr_relay

// >>> common/pscr_pkg.sv
package pscr_pkg;
   // ==================================================
   // clock and tick base
   // ==================================================
   localparam int unsigned CLK_PERIOD_PS = 25_000;
   localparam int unsigned TICK_PS = 1_000_000;
   localparam int unsigned PS_PER_US = 1_000_000;
   localparam int unsigned TICK_CYCLES = TICK_PS / CLK_PERIOD_PS;
   localparam int unsigned TICKS_PER_US = PS_PER_US / TICK_PS;
   localparam int unsigned DIV_W = 6;

   // ==================================================
   // link timing, as printed
   // ==================================================
   localparam int unsigned START_IN_MAX_US = 34;
   localparam int unsigned WARM_MIN_US = 42;
   localparam int unsigned START_OUT_US = 17;
   localparam int unsigned HIGH_MS = 40;
   localparam int unsigned LOW_NOM_MS = 80;
   localparam int unsigned TIMEOUT_MS = 600;

   // ==================================================
   // derived tick counts
   // ==================================================
   localparam int unsigned START_MAX_TICKS = START_IN_MAX_US * TICKS_PER_US;
   localparam int unsigned WARM_MIN_TICKS = WARM_MIN_US * TICKS_PER_US;
   localparam int unsigned START_OUT_TICKS = START_OUT_US * TICKS_PER_US;
   localparam int unsigned HIGH_TICKS = HIGH_MS * 1000 * TICKS_PER_US;
   localparam int unsigned LOW_NOM_TICKS = LOW_NOM_MS * 1000 * TICKS_PER_US;
   localparam int unsigned TIMEOUT_TICKS = TIMEOUT_MS * 1000 * TICKS_PER_US;
   localparam int unsigned DLY_TICKS = START_MAX_TICKS + 1;

   // ==================================================
   // widths and sizes
   // ==================================================
   localparam int unsigned CNT_W = 20;
   localparam int unsigned DATA_W = 20;
   localparam int unsigned FIFO_DEPTH = 32;
   localparam int unsigned STRAP_WAIT = 3;

   typedef enum logic [2:0] {
      ST_RELAY,
      ST_CONVERT,
      ST_OWN_HIGH,
      ST_OWN_LOW,
      ST_START_OUT
   } pscr_state_e;
endpackage : pscr_pkg

// >>> common/pscr_stream_if.sv
`timescale 1ns/1ps
interface pscr_stream_if #(
   parameter int unsigned W = 20
);
   logic valid;
   logic ready;
   logic [W-1:0] data;

   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface : pscr_stream_if

// >>> design/pscr_fifo.sv
`timescale 1ns/1ps
module pscr_fifo #(
   parameter int unsigned W = 20,
   parameter int unsigned DEPTH = 32
) (
   input wire logic clk,
   input wire logic rst,
   pscr_stream_if.snk wr,
   pscr_stream_if.src rd
);
   localparam int unsigned AW = $clog2(DEPTH);
   localparam int unsigned CW = $clog2(DEPTH + 1);

   logic [W-1:0] mem [DEPTH];
   logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
   logic [CW-1:0] cnt_q, cnt_d;
   logic in_rdy_q, in_rdy_d, out_vld_q, out_vld_d;
   logic push, pop;

   // ==================================================
   // pointers and flags
   // ==================================================
   always_comb begin
      push = wr.valid & in_rdy_q;
      pop = rd.ready & out_vld_q;
      wp_d = push ? wp_q + AW'(1) : wp_q;
      rp_d = pop ? rp_q + AW'(1) : rp_q;
      cnt_d = cnt_q;
      if (push & ~pop) begin
         cnt_d = cnt_q + CW'(1);
      end else if (pop & ~push) begin
         cnt_d = cnt_q - CW'(1);
      end
      // flags registered so the ports come straight from flops
      in_rdy_d = (cnt_d != CW'(DEPTH));
      out_vld_d = (cnt_d != CW'(0));
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wp_q <= '0;
         rp_q <= '0;
         cnt_q <= '0;
         in_rdy_q <= 1'b1;
         out_vld_q <= 1'b0;
      end else begin
         wp_q <= wp_d;
         rp_q <= rp_d;
         cnt_q <= cnt_d;
         in_rdy_q <= in_rdy_d;
         out_vld_q <= out_vld_d;
      end
   end

   // storage has no reset: contents are only read behind valid
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wp_q] <= wr.data;
      end
   end

   assign wr.ready = in_rdy_q;
   assign rd.valid = out_vld_q;
   assign rd.data = mem[rp_q];
endmodule : pscr_fifo

// >>> tb/pscr_relay_checker.sv
`timescale 1ns/1ps
module pscr_relay_checker #(
   parameter int unsigned HIGH_TICKS = 36,
   parameter int unsigned TIMEOUT_TICKS = 100,
   parameter int unsigned DATA_W = 20,
   parameter int unsigned FIFO_DEPTH = 32
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic chain_in,
   input wire logic mode_select_pin,
   input wire logic meas_valid,
   input wire logic [DATA_W-1:0] meas_data,
   input wire logic meas_ready,
   input wire logic chain_out,
   input wire logic conv_start,
   input wire logic powered,
   input wire logic osc_settled,
   input wire logic busy
);
   localparam int unsigned TC = pscr_pkg::TICK_CYCLES;
   localparam int unsigned LO_H = (HIGH_TICKS - 1) * TC - 2;
   localparam int unsigned HI_H = (HIGH_TICKS + 1) * TC;
   logic [31:0] hi_q;
   logic [31:0] hi_d;
   // counts one short: sampled before the edge
   always_comb begin
      hi_d = chain_out ? hi_q + 32'h0000_0001 : 32'h0000_0000;
   end
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         hi_q <= 32'h0000_0000;
      end else begin
         hi_q <= hi_d;
      end
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   chk_conv_busy: assert property (
      conv_start |-> busy && !chain_out) else $error("start without busy");
   chk_conv_pulse: assert property (
      conv_start |=> !conv_start) else $error("start pulse too long");
   chk_busy_end: assert property (
      $fell(busy) |-> $fell(chain_out) && hi_q >= 16 * TC - 2 && hi_q <= 18 * TC)
      else $error("bad start out");
   chk_own_high: assert property (
      $fell(chain_out) && busy |-> hi_q >= LO_H && hi_q <= HI_H) else $error("bad high");
   chk_pop_ready: assert property (
      conv_start && !meas_ready |-> ##[1:3] meas_ready) else $error("no pop");
   chk_down_clear: assert property (
      $fell(powered) |-> !osc_settled && !busy) else $error("bad power down");
   chk_warm_pow: assert property (
      $rose(osc_settled) |-> powered) else $error("settled while down");
   chk_strap_off: assert property (
      !mode_select_pin |-> !chain_out && !conv_start) else $error("chain active");
   cov_conv: cover property (conv_start);
   cov_full: cover property (!meas_ready);
   cov_down: cover property ($fell(powered));
endmodule : pscr_relay_checker
bind pscr_relay pscr_relay_checker #(.HIGH_TICKS(HIGH_TICKS), .TIMEOUT_TICKS(TIMEOUT_TICKS),
   .DATA_W(DATA_W), .FIFO_DEPTH(FIFO_DEPTH)) i_pscr_relay_checker (.ref_clk(ref_clk),
   .rst(rst), .chain_in(chain_in), .mode_select_pin(mode_select_pin),
   .meas_valid(meas_valid), .meas_data(meas_data), .meas_ready(meas_ready),
   .chain_out(chain_out), .conv_start(conv_start), .powered(powered),
   .osc_settled(osc_settled), .busy(busy));

// >>> tb/pscr_host_model.sv
`timescale 1ns/1ps
module pscr_host_model (
   input wire logic ref_clk,
   output logic chain_in
);
   initial chain_in = 1'b0;
   task automatic drive(input logic v, input int us);
      chain_in <= v;
      repeat (us * pscr_pkg::TICK_CYCLES) @(posedge ref_clk);
   endtask : drive
   task automatic start(input int us);
      drive(1'b1, (us > 33) ? 33 : us);
      chain_in <= 1'b0;
   endtask : start
   task automatic warm();
      drive(1'b1, 50);
      drive(1'b0, 10);
   endtask : warm
endmodule : pscr_host_model

// >>> tb/pscr_relay_tb_top.sv
`timescale 1ns/1ps
module pscr_relay_tb_top;
   localparam int HT = 36;
   localparam int TC = pscr_pkg::TICK_CYCLES;
   logic ref_clk, rst, mode_select_pin, meas_valid, chain_in;
   logic [pscr_pkg::DATA_W-1:0] meas_data;
   logic meas_ready, chain_out, conv_start, powered, osc_settled, busy;
   logic [31:0] seed_q = 32'h0000_0046;
   int err_total = 0;
   int cmp_count = 0;
   int cyc = 0;
   int unsigned w[32];
   int n, hi, lo, st;

   pscr_relay #(.HIGH_TICKS(HT), .TIMEOUT_TICKS(100)) i_pscr_relay (.ref_clk(ref_clk),
      .rst(rst), .chain_in(chain_in), .mode_select_pin(mode_select_pin),
      .meas_valid(meas_valid), .meas_data(meas_data), .meas_ready(meas_ready),
      .chain_out(chain_out), .conv_start(conv_start), .powered(powered),
      .osc_settled(osc_settled), .busy(busy));
   pscr_host_model i_pscr_host_model (.ref_clk(ref_clk), .chain_in(chain_in));

   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   // ==========
   // helpers
   // ==========
   function logic [31:0] rnd();
      seed_q = seed_q ^ (seed_q << 13);
      seed_q = seed_q ^ (seed_q >> 17);
      seed_q = seed_q ^ (seed_q << 5);
      return seed_q;
   endfunction : rnd
   // edges may jitter by one tick
   function logic near(input int v, input int t);
      return (v >= t * TC - 42) && (v <= t * TC + 42);
   endfunction : near
   task check(input logic seen, input logic exp);
      cmp_count++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] %0t seen %b expected %b", $time, seen, exp);
      end
   endtask : check
   task width(input logic lv, output int c);
      c = 0;
      while (chain_out === lv && c < 20000) begin
         @(negedge ref_clk);
         c++;
      end
   endtask : width
   task waitc(input int lim);
      n = 0;
      while (conv_start !== 1'b1 && n < lim) begin
         @(negedge ref_clk);
         n++;
      end
   endtask : waitc
   task do_reset(input logic m);
      rst <= 1'b1;
      mode_select_pin <= m;
      repeat (3) @(posedge ref_clk);
      rst <= 1'b0;
      repeat (10) @(posedge ref_clk);
   endtask : do_reset
   task wrap_up();
      $display("compares %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : wrap_up
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 105000) begin
         err_total++;
         wrap_up();
      end
   end
   // ==========
   // tests
   // ==========
   initial begin
      rst = 1'b1;
      mode_select_pin = 1'b0;
      meas_valid = 1'b0;
      meas_data = '0;
      do_reset(1'b0);
      @(negedge ref_clk);
      check({chain_out, conv_start, powered, osc_settled, busy, meas_ready} === 6'h09, 1'b1);
      @(posedge ref_clk);
      i_pscr_host_model.start(17);
      waitc(1000);
      check(conv_start | chain_out, 1'b0);
      $display("test strap done");
      @(posedge ref_clk);
      do_reset(1'b1);
      i_pscr_host_model.warm();
      @(negedge ref_clk);
      check(osc_settled & powered, 1'b1);
      @(posedge ref_clk);
      i_pscr_host_model.drive(1'b1, 110);
      @(negedge ref_clk);
      check(powered | osc_settled | conv_start, 1'b0);
      @(posedge ref_clk);
      i_pscr_host_model.drive(1'b0, 60);
      @(negedge ref_clk);
      check(powered & osc_settled, 1'b1);
      @(posedge ref_clk);
      i_pscr_host_model.drive(1'b1, 20);
      @(negedge ref_clk);
      check(chain_out, 1'b0);
      @(posedge ref_clk);
      i_pscr_host_model.drive(1'b1, 25);
      @(negedge ref_clk);
      check(chain_out, 1'b1);
      @(posedge ref_clk);
      i_pscr_host_model.drive(1'b0, 45);
      @(negedge ref_clk);
      check(chain_out, 1'b0);
      $display("test power done");
      @(posedge ref_clk);
      for (int i = 0; i < 32; i++) begin
         w[i] = rnd() % 4;
         meas_valid <= 1'b1;
         meas_data <= w[i][19:0];
         @(posedge ref_clk);
      end
      meas_valid <= 1'b0;
      @(posedge ref_clk);
      @(negedge ref_clk);
      check(meas_ready, 1'b0);
      for (int i = 0; i < 32; i++) begin
         @(posedge ref_clk);
         i_pscr_host_model.drive(1'b0, 2);
         i_pscr_host_model.start((i == 0) ? 33 : 1 + rnd() % 8);
         waitc(400);
         check(conv_start, 1'b1);
         width(1'b0, n);
         if (i == 0) check(meas_ready, 1'b1);
         width(1'b1, hi);
         check(near(hi, HT), 1'b1);
         width(1'b0, lo);
         check(near(lo, (w[i] == 0) ? 1 : w[i]), 1'b1);
         width(1'b1, st);
         check(near(st, 17), 1'b1);
         check(busy, 1'b0);
      end
      $display("test chain done");
      wrap_up();
   end
endmodule : pscr_relay_tb_top
